/* File: sss_seq.sv */
// Ramp/soak setpoint step sequencer with an APB register slave.
// How it works
// R1: soak time unit code 0 is 0.1 s, 1 is 1 s, 2 is 1 min.
// R2: remaining time always shown in the selected unit, ramp or soak.
// R3: seconds unit shows min.sec, saturating at 99.99.
// R4: minutes unit shows h.min, saturating at 99.99.
// R5: start mode 0 begins in the soak of step one.
// R6: start mode 1 ramps up from process value if below step one target.
// R7: start mode 2 ramps down from process value if above step one target.
// R8: end mode 0 stops after final soak and returns to ready.
// R9: end mode 1 returns to the ramp of step one.
// R10: loop ramp runs from final target to step one, ignoring start mode.
// R11: looping repeats without limit until ready is selected.
// R12: end mode 2 holds the final target until ready.
// R13: each step carries a PID group 1 to 8, output while active.
// R14: each step carries a ramp rate 0.0 to 999.9, zero means none.
// R15: active step count is 1 to 8, default 1.
// R16: zero rate or unchanged target skips the ramp.
// R17: zero soak time skips the soak.
// R18: advance only in run; ready parks at start of step one.
// R19: ramp moves setpoint by rate each second tick and clamps at target.
// R20: soak loads its time and counts down once per unit tick.
`timescale 1ns/100ps
`include "sss_defs.svh"
module sss_seq #(
    parameter int unsigned TENTH_CYC = `SSS_TENTH_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic signed [15:0] process_value,
    output logic signed [15:0]      local_setpoint,
    output logic [3:0]              pid_group,
    output logic [13:0]             remain_disp
);
    import sss_pkg::*;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic             run_q;
    logic [1:0]       soak_time_unit_sel_q;
    logic [1:0]       start_from_pv_mode_q;
    logic [1:0]       end_of_program_mode_q;
    logic [3:0]       active_step_count_q;
    logic             hw_stop;
    sss_step_t        cur;
    sss_step_t        bus_rd;
    sss_wr_t          tbl_wr;
    sss_tick_t        tick;
    sss_state_t       st_q, st_d;
    logic [2:0]       step_q, step_d;
    logic [15:0]      ramp_left_q, ramp_left_d;
    logic [13:0]      soak_left_q, soak_left_d;
    logic [16:0]      dist_q, dist_d;
    logic             up_q, up_d, first_q, first_d;
    logic signed [15:0] sp_q, sp_d;
    logic [3:0]       pid_q, pid_d;

    function automatic logic code_ok(input logic [1:0] c);
        return c != 2'h3;
    endfunction

    // Decode; the step table sits at 0x80 + step * 0x10 + field * 4.
    logic acc, wr_acc, is_tbl, is_ctrl, is_stat, is_sp, is_rem, mapped;
    logic wr_ctrl;
    logic [31:0] tbl_word;
    assign acc     = psel && penable;
    assign wr_acc  = acc && pwrite;
    assign is_tbl  = paddr[7] && paddr[1:0] == 2'b00;
    assign is_ctrl = paddr == `SSS_OFF_CTRL;
    assign is_stat = paddr == `SSS_OFF_STAT;
    assign is_sp   = paddr == `SSS_OFF_SP;
    assign is_rem  = paddr == `SSS_OFF_REM;
    assign mapped  = is_tbl || is_ctrl || is_stat || is_sp || is_rem;
    assign wr_ctrl = wr_acc && is_ctrl;
    assign tbl_wr  = '{en: wr_acc && is_tbl, idx: paddr[6:4],
                       fld: paddr[3:2], data: pwdata[15:0]};
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // Table read data is captured during setup, so no wait state.
    assign tbl_word = paddr[3:2] == 2'h0 ? {{16{bus_rd.sp[15]}}, bus_rd.sp}
                    : paddr[3:2] == 2'h1 ? {28'h0000000, bus_rd.pid}
                    : paddr[3:2] == 2'h2 ? {18'h00000, bus_rd.rate}
                    : {18'h00000, bus_rd.soak};
    assign prdata = !acc || pwrite ? 32'h00000000
        : is_ctrl ? {20'h00000, active_step_count_q, 1'b0,
                     end_of_program_mode_q, start_from_pv_mode_q,
                     soak_time_unit_sel_q, run_q}
        : is_stat ? {23'h000000, run_q, 1'b0, st_q, 1'b0, step_q}
        : is_sp   ? {{16{sp_q[15]}}, sp_q}
        : is_rem  ? {18'h00000, remain_disp}
        : is_tbl  ? tbl_word : 32'h00000000;

    // Control word; illegal codes are dropped, the end-of-program stop
    // beats a simultaneous software write of the run bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q                 <= 1'b0;
            soak_time_unit_sel_q  <= 2'h0; // see R1
            start_from_pv_mode_q  <= 2'h0;
            end_of_program_mode_q <= 2'h0;
            active_step_count_q   <= `SSS_CNT_RST;
        end else begin
            if (wr_ctrl) begin
                run_q <= pwdata[`SSS_RUN_BIT];
                if (code_ok(pwdata[`SSS_UNIT_LO +: 2]))
                    soak_time_unit_sel_q <= pwdata[`SSS_UNIT_LO +: 2];
                if (code_ok(pwdata[`SSS_START_LO +: 2]))
                    start_from_pv_mode_q <= pwdata[`SSS_START_LO +: 2];
                if (code_ok(pwdata[`SSS_END_LO +: 2]))
                    end_of_program_mode_q <= pwdata[`SSS_END_LO +: 2];
                if (pwdata[`SSS_CNT_LO +: 4] != 4'h0 &&
                    pwdata[`SSS_CNT_LO +: 4] <= 4'h8) // see R15
                    active_step_count_q <= pwdata[`SSS_CNT_LO +: 4];
            end
            if (hw_stop) run_q <= 1'b0; // see R8
        end
    end

    // ****************************************************************
    // Step table and time base
    // ****************************************************************
    sss_step_mem u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (tbl_wr),
        .addr_a  (step_d),
        .addr_b  (paddr[6:4]),
        .rd_a    (cur),
        .rd_b    (bus_rd)
    );

    sss_tick_gen #(.TENTH_CYC(TENTH_CYC)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    logic unit_tick, last_step, adv, start_up, start_dn;
    logic signed [16:0] gap, pv_gap;
    logic [16:0] rate17;
    assign unit_tick = soak_time_unit_sel_q == 2'h0 ? tick.tenth
                     : soak_time_unit_sel_q == 2'h1 ? tick.sec
                     : tick.min; // see R1
    assign last_step = 4'({1'b0, step_q}) + 4'h1 >= active_step_count_q;
    assign rate17    = {3'b000, cur.rate};
    assign gap       = up_q ? 17'(cur.sp - sp_q) : 17'(sp_q - cur.sp);
    assign pv_gap    = 17'(cur.sp - process_value);
    assign start_up  = start_from_pv_mode_q == 2'h1 && pv_gap > 0
                       && cur.rate != 14'h0000; // see R6
    assign start_dn  = start_from_pv_mode_q == 2'h2 && pv_gap < 0
                       && cur.rate != 14'h0000; // see R7

    // Next state; the table address follows step_d so data is ready
    // in the first cycle of each new step.
    always_comb begin
        st_d = st_q;
        step_d = step_q;
        sp_d = sp_q;
        pid_d = pid_q;
        ramp_left_d = ramp_left_q;
        soak_left_d = soak_left_q;
        dist_d = dist_q;
        up_d = up_q;
        first_d = first_q;
        adv = 1'b0;
        hw_stop = 1'b0;
        unique case (st_q)
            ST_PARK: begin
                sp_d = cur.sp;
                pid_d = cur.pid;
                ramp_left_d = 16'h0000;
                soak_left_d = 14'h0000;
                first_d = 1'b1;
                if (run_q) st_d = ST_FETCH;
            end
            ST_FETCH: begin
                first_d = 1'b0;
                pid_d = cur.pid; // see R13
                ramp_left_d = 16'h0000;
                if (first_q && (start_up || start_dn)) begin
                    sp_d = process_value;
                    up_d = start_up;
                    dist_d = start_up ? pv_gap : 17'(-pv_gap);
                    st_d = ST_CALC;
                end else if (first_q || cur.rate == 14'h0000
                             || sp_q == cur.sp) begin
                    sp_d = cur.sp; // see R5 see R16
                    st_d = ST_SOAK_IN;
                end else begin
                    up_d = sp_q < cur.sp; // see R10
                    dist_d = up_d ? 17'(cur.sp - sp_q) : 17'(sp_q - cur.sp);
                    st_d = ST_CALC;
                end
            end
            ST_CALC: begin
                // Ramp length in seconds for the remaining-time display.
                ramp_left_d = 16'(ramp_left_q + 16'h0001);
                if (dist_q > rate17) dist_d = 17'(dist_q - rate17);
                else st_d = ST_RAMP;
            end
            ST_RAMP: begin
                if (tick.sec) begin
                    if (ramp_left_q != 16'h0000)
                        ramp_left_d = 16'(ramp_left_q - 16'h0001);
                    if (gap <= $signed(rate17)) begin
                        sp_d = cur.sp; // see R19
                        st_d = ST_SOAK_IN;
                    end else begin
                        sp_d = up_q ? 16'(sp_q + $signed(rate17))
                                    : 16'(sp_q - $signed(rate17)); // see R14
                    end
                end
            end
            ST_SOAK_IN: begin
                ramp_left_d = 16'h0000;
                if (cur.soak == 14'h0000) adv = 1'b1; // see R17
                else begin
                    soak_left_d = cur.soak; // see R20
                    st_d = ST_SOAK;
                end
            end
            ST_SOAK: begin
                if (unit_tick) begin
                    if (soak_left_q == 14'h0001) adv = 1'b1;
                    soak_left_d = 14'(soak_left_q - 14'h0001); // see R20
                end
            end
            ST_HOLD: begin
                sp_d = sp_q; // see R12
            end
        endcase
        // Finishing the last step obeys the end-of-program mode.
        if (adv) begin
            if (!last_step) begin
                step_d = 3'(step_q + 3'h1);
                st_d = ST_FETCH;
            end else if (end_of_program_mode_q == 2'h0) begin
                hw_stop = 1'b1; // see R8
                st_d = ST_PARK;
            end else if (end_of_program_mode_q == 2'h1) begin
                step_d = 3'h0; // see R9 see R11
                st_d = ST_FETCH;
            end else begin
                st_d = ST_HOLD; // see R12
            end
        end
        // Leaving run always parks at the top of step one.
        if (!run_q) begin
            st_d = ST_PARK; // see R18
            step_d = 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_PARK;
            step_q <= 3'h0;
            sp_q <= 16'sh0000;
            pid_q <= `SSS_PID_RST;
            ramp_left_q <= 16'h0000;
            soak_left_q <= 14'h0000;
            dist_q <= 17'h00000;
            up_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            st_q <= st_d;
            step_q <= step_d;
            sp_q <= sp_d;
            pid_q <= pid_d;
            ramp_left_q <= ramp_left_d;
            soak_left_q <= soak_left_d;
            dist_q <= dist_d;
            up_q <= up_d;
            first_q <= first_d;
        end
    end

    // ****************************************************************
    // Remaining-time display
    // ****************************************************************
    logic [19:0] ramp_raw, raw;
    logic [13:0] disp_d;
    logic        ramping;
    assign ramping = st_q == ST_CALC || st_q == ST_RAMP;
    // Ramp time is kept in seconds and rescaled; minutes round up.
    assign ramp_raw = soak_time_unit_sel_q == 2'h0
                    ? 20'({4'h0, ramp_left_q} * `SSS_TENTHS_PER_S)
                    : soak_time_unit_sel_q == 2'h1 ? {4'h0, ramp_left_q}
                    : 20'(({4'h0, ramp_left_q} + `SSS_S_PER_MIN - 20'h00001)
                          / `SSS_S_PER_MIN); // see R2
    assign raw = ramping ? ramp_raw : {6'h00, soak_left_q};
    assign disp_d = soak_time_unit_sel_q == 2'h0
        ? (raw > {6'h00, `SSS_VAL_MAX} ? `SSS_VAL_MAX : raw[13:0])
        : raw >= `SSS_SAT_LIMIT ? `SSS_VAL_MAX // see R3 see R4
        : 14'(14'(raw / `SSS_S_PER_MIN) * `SSS_DISP_RADIX)
          + 14'(raw % `SSS_S_PER_MIN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) remain_disp <= 14'h0000;
        else remain_disp <= disp_d;
    end

    assign local_setpoint = sp_q;
    assign pid_group = pid_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_start;
        st_q == ST_FETCH && first_q && run_q;
    endsequence
    sequence s_last_done;
        adv && run_q && last_step;
    endsequence

    a_park_ready: assert property (!run_q |=> st_q == ST_PARK && step_q == 3'h0) else $error("not parked in ready"); // see R18
    a_pid_follow: assert property (st_q == ST_FETCH |=> pid_group == $past(cur.pid)) else $error("pid group not taken"); // see R13
    a_plain_start: assert property (s_start ##0 start_from_pv_mode_q == 2'h0 |=> st_q == ST_SOAK_IN && sp_q == $past(cur.sp)) else $error("mode 0 did not soak"); // see R5
    a_up_start: assert property (s_start ##0 start_up |=> st_q == ST_CALC && up_q && sp_q == $past(process_value)) else $error("up start wrong"); // see R6
    a_down_start: assert property (s_start ##0 start_dn |=> st_q == ST_CALC && !up_q && sp_q == $past(process_value)) else $error("down start wrong"); // see R7
    a_end_stop: assert property (s_last_done ##0 end_of_program_mode_q == 2'h0 |=> !run_q ##1 st_q == ST_PARK) else $error("end did not stop"); // see R8
    a_loop_back: assert property (s_last_done ##0 end_of_program_mode_q == 2'h1 |=> st_q == ST_FETCH && step_q == 3'h0 && !first_q) else $error("loop not taken"); // see R9
    a_hold_stays: assert property (st_q == ST_HOLD && run_q |=> st_q == ST_HOLD && $stable(sp_q)) else $error("hold moved"); // see R12
    a_soak_count: assert property (st_q == ST_SOAK && run_q && unit_tick && soak_left_q > 14'h0001 |=> soak_left_q == $past(soak_left_q) - 14'h0001) else $error("soak count wrong"); // see R20
    a_ramp_clamp: assert property (st_q == ST_RAMP && up_q |-> sp_q <= cur.sp) else $error("ramp overshoot"); // see R19
    a_sat_disp: assert property (soak_time_unit_sel_q != 2'h0 && raw >= `SSS_SAT_LIMIT |=> remain_disp == `SSS_VAL_MAX) else $error("no saturation"); // see R3
endmodule

/* File: sss_defs.svh */
// Offsets, field positions, reset values and timing counts of the sequencer.
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH
`define SSS_OFF_CTRL     8'h00
`define SSS_OFF_STAT     8'h04
`define SSS_OFF_SP       8'h08
`define SSS_OFF_REM      8'h0C
`define SSS_RUN_BIT      0
`define SSS_UNIT_LO      1
`define SSS_START_LO     3
`define SSS_END_LO       5
`define SSS_CNT_LO       8
`define SSS_CNT_RST      4'h1
`define SSS_PID_RST      4'h1
`define SSS_PID_MAX      4'h8
`define SSS_VAL_MAX      14'h270F
`define SSS_SAT_LIMIT    20'h0176F
`define SSS_TENTHS_PER_S 20'h0000A
`define SSS_S_PER_MIN    20'h0003C
`define SSS_DISP_RADIX   14'h0064
`define SSS_CLK_NS       32'h00000064
`define SSS_TENTH_NS     32'h05F5E100
`define SSS_TENTH_CYC    (`SSS_TENTH_NS / `SSS_CLK_NS)
`endif

/* File: sss_pkg.sv */
// Types shared by the setpoint step sequencer modules.
package sss_pkg;
    typedef struct packed {
        logic signed [15:0] sp;
        logic [3:0]         pid;
        logic [13:0]        rate;
        logic [13:0]        soak;
    } sss_step_t;
    typedef struct packed {
        logic tenth;
        logic sec;
        logic min;
    } sss_tick_t;
    typedef struct packed {
        logic        en;
        logic [2:0]  idx;
        logic [1:0]  fld;
        logic [15:0] data;
    } sss_wr_t;
    typedef enum logic [2:0] {
        ST_PARK, ST_FETCH, ST_CALC, ST_RAMP, ST_SOAK_IN, ST_SOAK, ST_HOLD
    } sss_state_t;
endpackage

/* File: sss_tick_gen.sv */
// Time base: tenth-second, second and minute tick pulses.
`timescale 1ns/100ps
`include "sss_defs.svh"
module sss_tick_gen #(
    parameter int unsigned TENTH_CYC = `SSS_TENTH_CYC
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    output sss_pkg::sss_tick_t tick
);
    import sss_pkg::*;
    localparam int W = (TENTH_CYC > 1) ? $clog2(TENTH_CYC) : 1;
    logic [W-1:0] pre_q;
    logic [3:0]   ten_q;
    logic [5:0]   sec_q;
    logic         pre_end;
    logic         ten_end;
    logic         sec_end;

    // Each tick is the carry of the stage below it.
    assign pre_end = pre_q == W'(TENTH_CYC - 1);
    assign ten_end = pre_end && ten_q == 4'h9;
    assign sec_end = ten_end && sec_q == 6'h3B;

    // Cascaded counters; pulses leave from flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
            ten_q <= 4'h0;
            sec_q <= 6'h00;
            tick  <= '0;
        end else begin
            pre_q <= pre_end ? '0 : W'(pre_q + 1'b1);
            if (pre_end) ten_q <= ten_end ? 4'h0 : 4'(ten_q + 4'h1);
            if (ten_end) sec_q <= sec_end ? 6'h00 : 6'(sec_q + 6'h01);
            tick  <= '{tenth: pre_end, sec: ten_end, min: sec_end};
        end
    end
endmodule

/* File: sss_step_mem.sv */
// Table of eight steps with one write port and two registered read ports.
`timescale 1ns/100ps
`include "sss_defs.svh"
module sss_step_mem (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  sss_pkg::sss_wr_t   wr,
    input  wire logic [2:0]    addr_a,
    input  wire logic [2:0]    addr_b,
    output sss_pkg::sss_step_t rd_a,
    output sss_pkg::sss_step_t rd_b
);
    import sss_pkg::*;
    localparam sss_step_t RST = '{sp: 16'sh0000, pid: `SSS_PID_RST,
                                  rate: 14'h0000, soak: 14'h0000};
    sss_step_t mem_q [8];
    logic      pid_ok;
    logic      val_ok;

    // Out-of-range values are dropped so the table always stays legal.
    assign pid_ok = wr.data[15:4] == 12'h000 && wr.data[3:0] != 4'h0
                    && wr.data[3:0] <= `SSS_PID_MAX;
    assign val_ok = wr.data <= {2'b00, `SSS_VAL_MAX};

    // One field of one entry is written per bus write.
    for (genvar i = 0; i < 8; i++) begin : g_ent
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem_q[i] <= RST;
            end else if (wr.en && wr.idx == 3'(i)) begin
                unique case (wr.fld)
                    2'h0: mem_q[i].sp <= wr.data;
                    2'h1: if (pid_ok) mem_q[i].pid <= wr.data[3:0];
                    2'h2: if (val_ok) mem_q[i].rate <= wr.data[13:0];
                    2'h3: if (val_ok) mem_q[i].soak <= wr.data[13:0];
                endcase
            end
        end
    end

    // Read data registered; callers present the address one edge early.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_a <= RST;
            rd_b <= RST;
        end else begin
            rd_a <= mem_q[addr_a];
            rd_b <= mem_q[addr_b];
        end
    end
endmodule

/* File: tb_sss_seq.sv */
// Self-checking testbench of the setpoint step sequencer.
`timescale 1ns/100ps
module tb_sss_seq;
    // ****************
    // Signals
    // ****************
    logic               pclk;
    logic               presetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic signed [15:0] pv;
    logic signed [15:0] sp;
    logic [3:0]         pid;
    logic [13:0]        rem;
    logic [31:0]        q;
    logic signed [15:0] sp_s;
    logic               err_q;
    int                 miscompares;
    int                 num_checks;
    int                 sm[5] = '{0, 1, 1, 2, 2};
    int                 spv[5] = '{-50, -50, 200, 200, -50};
    int                 su[5] = '{0, 1, 1, 2, 2};
    int                 st[5] = '{125, 125, 6000, 125, 6000};
    int                 se[5] = '{125, 205, 9999, 205, 9999};

    // A short tenth tick keeps seconds at 40 cycles.
    sss_seq #(.TENTH_CYC(4)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .process_value(pv),
        .local_setpoint(sp), .pid_group(pid), .remain_disp(rem));

    // Clock of 100 ns period.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Watchdog; the tests need far fewer cycles than this.
    initial begin
        #(100 * 60000);
        miscompares++;
        complete_run();
    end

    // ****************
    // Tasks
    // ****************
    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; data, error and setpoint are taken at the pready
    // edge, so a status read and the setpoint beside it always agree.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) miscompares++;
        q = prdata;
        err_q = pslverr;
        sp_s = sp;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic ws(input int s, input int f, input int v);
        apb(1'b1, 8'(128 + s * 16 + f * 4), 32'(v));
    endtask

    // Polls the status word until the sequencer state matches.
    task automatic wait_st(input logic [2:0] s);
        int n;
        n = 0;
        apb(1'b0, 8'h04, 32'h0);
        while (q[6:4] !== s && n < 2000) begin
            n++;
            apb(1'b0, 8'h04, 32'h0);
        end
        if (q[6:4] !== s) miscompares++;
    endtask

    // ****************
    // Tests
    // ****************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pv = 16'sh0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", q, 32'h00000100);
        check("pid out", pid, 32'h1);
        apb(1'b0, 8'h94, 32'h0);
        check("pid reg", q, 32'h1);
        apb(1'b0, 8'h88, 32'h0);
        check("rate reg", q, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", err_q, 32'h1);
        $display("test reset done");
        // Start modes: a slow ramp stays away from the target a while.
        ws(0, 0, 100);
        ws(0, 1, 3);
        ws(0, 2, 10);
        ws(0, 3, 9999);
        for (int i = 0; i < 5; i++) begin
            pv <= 16'(spv[i]);
            apb(1'b1, 8'h00, 32'h101 | 32'(sm[i] << 3));
            wait_st((i == 1 || i == 3) ? 3'd3 : 3'd5);
            check("ramp", sp !== 16'sd100, (i == 1 || i == 3));
            check("pid run", pid, 32'h3);
            apb(1'b1, 8'h00, 32'h100);
            wait_st(3'd0);
            check("park", q[8:0], 32'h0);
        end
        $display("test start modes done");
        // End modes over two steps; the second skips its ramp and soak.
        ws(0, 2, 9999);
        ws(0, 3, 2);
        ws(1, 0, 300);
        ws(1, 1, 5);
        ws(1, 3, 0);
        apb(1'b1, 8'h00, 32'h201);
        wait_st(3'd0);
        check("stop", q[8], 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check("stop sp", q, 32'd100);
        apb(1'b1, 8'h00, 32'h221);
        for (int i = 0; i < 2; i++) begin
            wait_st(3'd5);
            wait_st(3'd3);
            check("loop", {q[8], q[2:0]}, 32'h8);
            check("loop sp", sp_s, 32'd300);
        end
        apb(1'b1, 8'h00, 32'h240);
        apb(1'b1, 8'h00, 32'h241);
        wait_st(3'd6);
        check("hold", {q[8], q[2:0]}, 32'h9);
        check("hold sp", sp, 32'd300);
        check("hold pid", pid, 32'h5);
        apb(1'b1, 8'h00, 32'h100);
        $display("test end modes done");
        // Remaining display per unit; a tick may land before the read.
        ws(0, 2, 0);
        for (int i = 0; i < 5; i++) begin
            ws(0, 3, st[i]);
            apb(1'b1, 8'h00, 32'h101 | 32'(su[i] << 1));
            wait_st(3'd5);
            check("remain", (rem <= se[i] && rem + 3 >= se[i]), 1);
            apb(1'b1, 8'h00, 32'h100);
            wait_st(3'd0);
        end
        $display("test display done");
        complete_run();
    end
endmodule
